// ### hw/csl_pkg.sv
// constants and types for the coupler status lamp driver
// assumes a single 40 MHz system clock shared by all design files
package csl_pkg;

    // ------------------------------------------------------------------
    // clock and pattern timing
    // ------------------------------------------------------------------
    localparam int CSL_CLK_HZ          = 40000000;
    localparam int CSL_FLASH_HALF_MS   = 200;   // flashing on / off phase
    localparam int CSL_SINGLE_ON_MS    = 200;   // single flash lit phase
    localparam int CSL_SINGLE_OFF_MS   = 1000;  // single flash dark phase
    localparam int CSL_FLICKER_HALF_MS = 50;    // flicker on / off phase
    localparam int CSL_ACT_HOLD_MS     = 50;    // activity stretch time
    localparam int CSL_MS_DIV          = 1000;

    // cycles per phase, rounded down since these are longest figures
    localparam int CSL_FLASH_HALF_CYC =
        CSL_CLK_HZ / CSL_MS_DIV * CSL_FLASH_HALF_MS;
    localparam int CSL_SINGLE_ON_CYC =
        CSL_CLK_HZ / CSL_MS_DIV * CSL_SINGLE_ON_MS;
    localparam int CSL_SINGLE_OFF_CYC =
        CSL_CLK_HZ / CSL_MS_DIV * CSL_SINGLE_OFF_MS;
    localparam int CSL_FLICKER_HALF_CYC =
        CSL_CLK_HZ / CSL_MS_DIV * CSL_FLICKER_HALF_MS;
    localparam int CSL_ACT_HOLD_CYC =
        CSL_CLK_HZ / CSL_MS_DIV * CSL_ACT_HOLD_MS;

    localparam int CSL_CNT_W = 32;

    // ------------------------------------------------------------------
    // slave state encoding on the state input
    // ------------------------------------------------------------------
    localparam logic [3:0] CSL_ST_INIT   = 4'h1;
    localparam logic [3:0] CSL_ST_PREOP  = 4'h2;
    localparam logic [3:0] CSL_ST_BOOT   = 4'h3;
    localparam logic [3:0] CSL_ST_SAFEOP = 4'h4;
    localparam logic [3:0] CSL_ST_OP     = 4'h8;

    // lamp pattern selected for the status lamp
    typedef enum logic [4:0] {
        CSL_PAT_OFF     = 5'h01,
        CSL_PAT_FLASH   = 5'h02,
        CSL_PAT_SINGLE  = 5'h04,
        CSL_PAT_ON      = 5'h08,
        CSL_PAT_FLICKER = 5'h10
    } csl_pat_t;

endpackage

// ### hw/csl_sync.sv
// two flip-flop synchroniser for a vector of pin levels
// assumes the inputs are asynchronous to clk_sys
module csl_sync
    import csl_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;

    // ------------------------------------------------------------------
    // first stage feeds only the second stage
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule

// ### hw/csl_link_lamp.sv
// one link/activity lamp: dark, steady or flashing
// assumes link and activity are already synchronised to clk_sys
module csl_link_lamp
    import csl_pkg::*;
#(
    parameter int HOLD_CYC = CSL_ACT_HOLD_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic link_up,
    input  wire logic activity,
    input  wire logic flash_phase,
    output logic      lamp_ff
);

    logic [CSL_CNT_W-1:0] hold_ff;
    logic                 busy;

    // ------------------------------------------------------------------
    // stretch short activity pulses so the flashing is visible
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hold_ff <= '0;
        end else if (!link_up) begin
            hold_ff <= '0;
        end else if (activity) begin
            hold_ff <= CSL_CNT_W'(HOLD_CYC);
        end else if (hold_ff != '0) begin
            hold_ff <= hold_ff - 1'b1;
        end
    end

    assign busy = activity || (hold_ff != '0);

    // lamp: dark without link, lit when idle, flashing with traffic
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lamp_ff <= 1'b0;
        end else if (!link_up) begin
            lamp_ff <= 1'b0;                  // dark, no link
        end else if (busy) begin
            lamp_ff <= flash_phase;           // traffic flashing
        end else begin
            lamp_ff <= 1'b1;                  // linked and idle
        end
    end

endmodule

// ### hw/csl_top.sv
// coupler status lamp driver: status, link/activity and supply lamps
// assumes all status inputs are pins, asynchronous to clk_sys
//
// Summary of operation
// R01 - status lamp dark in init state
// R02 - status lamp flashing in pre-operational state
// R03 - status lamp single flash in safe-operational
// R04 - status lamp steady on when operational
// R05 - status lamp flickers during bootstrap loading
// R06 - upstream lamp dark without link
// R07 - upstream lamp steady when linked and idle
// R08 - upstream lamp flashes during frame traffic
// R09 - downstream lamp dark without link
// R10 - downstream lamp steady when linked and idle
// R11 - downstream lamp flashes during frame traffic
// R12 - backplane lamp dark without connection
// R13 - backplane lamp steady when connected, idle
// R14 - backplane lamp flashes during backplane traffic
// R15 - logic supply lamp follows supply flag
// R16 - power contact lamp follows contact flag
// R17 - patterns from free-running divider, parameterised
//
// lamp latency after a pin change: supply and link lamps three
// clocks, status lamp four (one extra for the pattern select)
// the blink generators free-run from reset and are shared, so all
// flashing lamps blink in step; a state change never restarts them
module csl_top
    import csl_pkg::*;
#(
    // half periods and phase lengths, all in clk_sys cycles
    parameter int FLASH_HALF_CYC   = CSL_FLASH_HALF_CYC,
    parameter int SINGLE_ON_CYC    = CSL_SINGLE_ON_CYC,
    parameter int SINGLE_OFF_CYC   = CSL_SINGLE_OFF_CYC,
    parameter int FLICKER_HALF_CYC = CSL_FLICKER_HALF_CYC,
    parameter int ACT_HOLD_CYC     = CSL_ACT_HOLD_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // state and port indications, pins from other clock domains
    input  wire logic [3:0] slave_state,
    input  wire logic       upstream_port_link,
    input  wire logic       upstream_port_act,
    input  wire logic       downstream_port_link,
    input  wire logic       downstream_port_act,
    input  wire logic       backplane_link,
    input  wire logic       backplane_act,
    // supply monitors, high while the supply is present
    input  wire logic       logic_supply_ok,
    input  wire logic       power_contact_ok,
    // lamp drives, high for lit
    output logic            status_lamp_ff,
    output logic            upstream_link_activity_lamp,
    output logic            downstream_link_activity_lamp,
    output logic            backplane_link_activity_lamp,
    output logic            logic_supply_lamp_ff,
    output logic            power_contact_lamp_ff
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    // every phase needs one clock at least, or its counter wraps the
    // full 32 bits before it ends
    if (FLASH_HALF_CYC < 1) begin : g_bad_flash
        $error("csl_top: FLASH_HALF_CYC must be at least 1");
    end
    if (SINGLE_ON_CYC < 1) begin : g_bad_son
        $error("csl_top: SINGLE_ON_CYC must be at least 1");
    end
    if (SINGLE_OFF_CYC < 1) begin : g_bad_soff
        $error("csl_top: SINGLE_OFF_CYC must be at least 1");
    end
    if (FLICKER_HALF_CYC < 1) begin : g_bad_flick
        $error("csl_top: FLICKER_HALF_CYC must be at least 1");
    end
    if (ACT_HOLD_CYC < 1) begin : g_bad_hold
        $error("csl_top: ACT_HOLD_CYC must be at least 1");
    end

    // flicker must look faster than flashing, or the two read alike
    if (FLICKER_HALF_CYC >= FLASH_HALF_CYC) begin : g_slow_flick
        $error("csl_top: flicker must be faster than flashing");
    end

    // single flash reads as such only with a dark gap over the lit time
    if (SINGLE_OFF_CYC <= SINGLE_ON_CYC) begin : g_short_gap
        $error("csl_top: single flash dark phase too short");
    end

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    // the pin may drop at any moment and clears everything at once;
    // only its release is retimed, so all registers below leave reset
    // on one edge and no blink counter starts ahead of the others
    logic rst_meta_ff;
    logic rst_n_ff;

    // async assert, synchronous release through two stages
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    localparam int SYNC_W = 12;

    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;
    logic [3:0]        state_s;
    logic              up_link_s;
    logic              up_act_s;
    logic              dn_link_s;
    logic              dn_act_s;
    logic              bp_link_s;
    logic              bp_act_s;
    logic              us_ok_s;
    logic              up_ok_s;

    // all pins share one synchroniser; each bit is an independent
    // level, so no word needs a handshake across the boundary
    assign pins_async = {slave_state, upstream_port_link, upstream_port_act,
                         downstream_port_link, downstream_port_act,
                         backplane_link, backplane_act,
                         logic_supply_ok, power_contact_ok};

    // reset by the retimed copy, so the stages clear with the rest
    csl_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n_ff),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    // state code may be caught mid-change; it settles within a cycle,
    // and a passing code shows dark, flicker if it reads as the boot code or flashing if it reads as the pre-op code, for that one cycle
    assign {state_s, up_link_s, up_act_s, dn_link_s, dn_act_s,
            bp_link_s, bp_act_s, us_ok_s, up_ok_s} = pins_sync;

    // ------------------------------------------------------------------
    // pattern generators
    // ------------------------------------------------------------------
    // three shared generators feed the status and link lamps; sharing keeps all
    // flashing lamps in step, which an operator reads more easily
    // than lamps that drift against each other
    logic [CSL_CNT_W-1:0] flash_cnt_ff;
    logic                 flash_ph_ff;
    logic [CSL_CNT_W-1:0] flick_cnt_ff;
    logic                 flick_ph_ff;
    logic [CSL_CNT_W-1:0] single_cnt_ff;
    logic                 single_ph_ff;

    // regular flashing, equal on and off halves [R17]
    // the phase starts dark after reset, so the first half is off
    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            flash_cnt_ff <= '0;
            flash_ph_ff  <= 1'b0;
        end else if (flash_cnt_ff == CSL_CNT_W'(FLASH_HALF_CYC - 1)) begin
            flash_cnt_ff <= '0;
            flash_ph_ff  <= ~flash_ph_ff;
        end else begin
            flash_cnt_ff <= flash_cnt_ff + 1'b1;
        end
    end

    // fast flicker, shorter halves [R17]
    // same shape as flashing, only the half period differs
    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            flick_cnt_ff <= '0;
            flick_ph_ff  <= 1'b0;
        end else if (flick_cnt_ff ==
                     CSL_CNT_W'(FLICKER_HALF_CYC - 1)) begin
            flick_cnt_ff <= '0;
            flick_ph_ff  <= ~flick_ph_ff;
        end else begin
            flick_cnt_ff <= flick_cnt_ff + 1'b1;
        end
    end

    // single flash: short lit phase, long dark phase [R17]
    // starts in the dark phase; the count restarts at each phase
    // change, so one counter serves both phase lengths
    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            single_cnt_ff <= '0;
            single_ph_ff  <= 1'b0;
        end else if (single_ph_ff &&
                     single_cnt_ff == CSL_CNT_W'(SINGLE_ON_CYC - 1)) begin
            single_cnt_ff <= '0;
            single_ph_ff  <= 1'b0;
        end else if (!single_ph_ff &&
                     single_cnt_ff == CSL_CNT_W'(SINGLE_OFF_CYC - 1)) begin
            single_cnt_ff <= '0;
            single_ph_ff  <= 1'b1;
        end else begin
            single_cnt_ff <= single_cnt_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // status lamp
    // ------------------------------------------------------------------
    // the pattern is registered once, so a code caught mid-change
    // costs one clock of dark, flicker or flashing at most and never a half-decoded pattern
    csl_pat_t nxt_pat;
    csl_pat_t pat_ff;

    // unknown state codes show dark, the safest reading for an operator
    always_comb begin
        case (state_s)
            CSL_ST_INIT:   nxt_pat = CSL_PAT_OFF;      // [R01]
            CSL_ST_PREOP:  nxt_pat = CSL_PAT_FLASH;    // [R02]
            CSL_ST_SAFEOP: nxt_pat = CSL_PAT_SINGLE;   // [R03]
            CSL_ST_OP:     nxt_pat = CSL_PAT_ON;       // [R04]
            CSL_ST_BOOT:   nxt_pat = CSL_PAT_FLICKER;  // [R05]
            default:       nxt_pat = CSL_PAT_OFF;
        endcase
    end

    // pattern select register, one clock of the status latency
    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pat_ff <= CSL_PAT_OFF;
        end else begin
            pat_ff <= nxt_pat;
        end
    end

    // pattern to lamp level
    // the lamp is a register, so no decode glitch reaches the pin
    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            status_lamp_ff <= 1'b0;
        end else begin
            case (pat_ff)
                CSL_PAT_OFF:     status_lamp_ff <= 1'b0;         // [R01]
                CSL_PAT_FLASH:   status_lamp_ff <= flash_ph_ff;  // [R02]
                CSL_PAT_SINGLE:  status_lamp_ff <= single_ph_ff; // [R03]
                CSL_PAT_ON:      status_lamp_ff <= 1'b1;         // [R04]
                CSL_PAT_FLICKER: status_lamp_ff <= flick_ph_ff;  // [R05]
                default:         status_lamp_ff <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // link/activity lamps
    // ------------------------------------------------------------------
    // one instance per lamp; each stretches its own activity so a
    // single short frame still gives a visible blink, and all use
    // the shared flash phase so busy ports blink in step
    logic [2:0] lk_link;
    logic [2:0] lk_act;
    logic [2:0] lk_lamp;

    assign lk_link = {bp_link_s, dn_link_s, up_link_s};
    assign lk_act  = {bp_act_s, dn_act_s, up_act_s};

    // index 0 upstream, 1 downstream, 2 backplane
    for (genvar i = 0; i < 3; i++) begin : g_link
        csl_link_lamp #(
            .HOLD_CYC (ACT_HOLD_CYC)
        ) u_lamp (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n_ff),
            .link_up     (lk_link[i]),   // [R06] [R09] [R12]
            .activity    (lk_act[i]),    // [R08] [R11] [R14]
            .flash_phase (flash_ph_ff),  // [R08] [R11] [R14]
            .lamp_ff     (lk_lamp[i])
        );
    end

    // lamp vector order is fixed here and at the link vectors above
    assign upstream_link_activity_lamp   = lk_lamp[0];
    assign downstream_link_activity_lamp = lk_lamp[1];
    assign backplane_link_activity_lamp  = lk_lamp[2];

    // ------------------------------------------------------------------
    // supply lamps
    // ------------------------------------------------------------------
    // plain levels one register behind the synchroniser; a dropping
    // supply shows dark three clocks after the pin falls
    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            logic_supply_lamp_ff  <= 1'b0;
            power_contact_lamp_ff <= 1'b0;
        end else begin
            logic_supply_lamp_ff  <= us_ok_s;   // [R15]
            power_contact_lamp_ff <= up_ok_s;   // [R16]
        end
    end

endmodule

// ### test/csl_top_props.sv
// checker for the status lamp driver, bound onto csl_top
// assumes one clock domain and the top's own port names
module csl_top_props
    import csl_pkg::*;
#(
    parameter int FLASH_HALF_CYC = CSL_FLASH_HALF_CYC,
    parameter int ACT_HOLD_CYC   = CSL_ACT_HOLD_CYC
) (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic [3:0] slave_state,
    input wire logic       upstream_port_link,
    input wire logic       upstream_port_act,
    input wire logic       backplane_link,
    input wire logic       logic_supply_ok,
    input wire logic       power_contact_ok,
    input wire logic       status_lamp_ff,
    input wire logic       upstream_link_activity_lamp,
    input wire logic       backplane_link_activity_lamp,
    input wire logic       logic_supply_lamp_ff,
    input wire logic       power_contact_lamp_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  wake_ff;  // sync stages refill after reset release
    logic [31:0] run_ff;   // length of current lit run
    logic [31:0] pre_ff;   // cycles spent in pre-operational
    logic [31:0] idle_ff;  // cycles upstream linked and quiet
    logic        ready;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // helper counters, cleared with the design
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wake_ff <= 4'h0;
            run_ff  <= 32'h0;
            pre_ff  <= 32'h0;
            idle_ff <= 32'h0;
        end else begin
            if (wake_ff != 4'hf) wake_ff <= wake_ff + 4'h1;
            run_ff  <= status_lamp_ff ? run_ff + 32'h1 : 32'h0;
            pre_ff  <= (slave_state == CSL_ST_PREOP) ? pre_ff + 32'h1 : 32'h0;
            idle_ff <= (upstream_port_link && !upstream_port_act) ?
                       idle_ff + 32'h1 : 32'h0;
        end
    end
    assign ready = (wake_ff == 4'hf);
    a_supply_lamp_follow: assert property (
        ready |-> logic_supply_lamp_ff == $past(logic_supply_ok, 3))
        else $error("logic supply lamp not following its flag");
    a_contact_lamp_follow: assert property (
        ready |-> power_contact_lamp_ff == $past(power_contact_ok, 3))
        else $error("power contact lamp not following its flag");
    a_up_dark_nolink: assert property (
        (ready && !upstream_port_link) [*4] |-> !upstream_link_activity_lamp)
        else $error("upstream lamp lit without link");
    a_bp_dark_nolink: assert property (
        (ready && !backplane_link) [*4] |-> !backplane_link_activity_lamp)
        else $error("backplane lamp lit without connection");
    a_up_steady_idle: assert property (
        ready && idle_ff > 32'(ACT_HOLD_CYC + 6)
        |-> upstream_link_activity_lamp)
        else $error("upstream lamp not steady while idle");
    a_status_op_on: assert property (
        (ready && slave_state == CSL_ST_OP) [*5] |-> status_lamp_ff)
        else $error("status lamp dark while operational");
    a_status_init_dark: assert property (
        (ready && slave_state == CSL_ST_INIT) [*5] |-> !status_lamp_ff)
        else $error("status lamp lit in init state");
    // full-phase runs only: the state held across the whole lit run
    a_status_flash_half: assert property (
        ready && $fell(status_lamp_ff) && pre_ff > run_ff + 32'd6
        |-> run_ff == 32'(FLASH_HALF_CYC))
        else $error("status flash lit phase has wrong length");
    c_flash_seen: cover property (
        ready && $fell(status_lamp_ff) && pre_ff > run_ff + 32'd6);
    c_idle_steady: cover property (ready && idle_ff > 32'(ACT_HOLD_CYC + 6));
    c_up_active: cover property (
        upstream_port_act && $rose(upstream_link_activity_lamp));
endmodule

bind csl_top csl_top_props #(
    .FLASH_HALF_CYC(FLASH_HALF_CYC),
    .ACT_HOLD_CYC  (ACT_HOLD_CYC)
) i_props (
    .clk_sys(clk_sys), .reset_n(reset_n), .slave_state(slave_state),
    .upstream_port_link(upstream_port_link),
    .upstream_port_act(upstream_port_act),
    .backplane_link(backplane_link),
    .logic_supply_ok(logic_supply_ok), .power_contact_ok(power_contact_ok),
    .status_lamp_ff(status_lamp_ff),
    .upstream_link_activity_lamp(upstream_link_activity_lamp),
    .backplane_link_activity_lamp(backplane_link_activity_lamp),
    .logic_supply_lamp_ff(logic_supply_lamp_ff),
    .power_contact_lamp_ff(power_contact_lamp_ff)
);

// ### test/csl_lamp_observer.sv
// operator's eye on one lamp: counts lit cycles and turn-on events
// assumes clear is raised for one cycle at the start of a window
module csl_lamp_observer (
    input  wire logic       clk_sys,
    input  wire logic       clear,
    input  wire logic       lamp,
    output logic      [7:0] lit_cnt_ff,
    output logic      [7:0] rise_cnt_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_ff;
    // prev kept through clear so a rise at the window start still counts
    always_ff @(posedge clk_sys) begin
        prev_ff <= lamp;
        if (clear) begin
            lit_cnt_ff  <= 8'h00;
            rise_cnt_ff <= 8'h00;
        end else begin
            lit_cnt_ff  <= lit_cnt_ff + 8'(lamp);
            rise_cnt_ff <= rise_cnt_ff + 8'(lamp & ~prev_ff);
        end
    end
endmodule

// ### test/test_coupler_status_led_driver.sv
// top testbench for the coupler status lamp driver
// assumes csl_top, its checker and the lamp observer are compiled first
module test_coupler_status_led_driver
    import csl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // short pattern counts; the window is a whole number of every period
    localparam int FH = 4, SON = 3, SOFF = 10, FK = 2, HOLD = 5, WIN = 104;
    localparam int FL_LIT = WIN / 2, FL_RISE = WIN / (2 * FH);
    localparam int SG_RISE = WIN / (SON + SOFF), SG_LIT = SG_RISE * SON;
    localparam int FK_RISE = WIN / (2 * FK);
    logic       clk_sys, reset_n, clr, lamp;
    logic       st_l, up_l, dn_l, bp_l, ls_l, pc_l;
    logic [3:0] slave_state;
    logic [5:0] ports;  // up link, up act, down link, down act, backplane link, backplane act
    logic [1:0] sel, supply;
    logic [7:0] lit_cnt, rise_cnt;
    int         failures, samples_checked;
    assign lamp = sel[1] ? (sel[0] ? bp_l : dn_l) : (sel[0] ? up_l : st_l);
    csl_top #(.FLASH_HALF_CYC(FH), .SINGLE_ON_CYC(SON),
        .SINGLE_OFF_CYC(SOFF), .FLICKER_HALF_CYC(FK), .ACT_HOLD_CYC(HOLD)
    ) i_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .slave_state(slave_state),
        .upstream_port_link(ports[5]), .upstream_port_act(ports[4]),
        .downstream_port_link(ports[3]), .downstream_port_act(ports[2]),
        .backplane_link(ports[1]), .backplane_act(ports[0]),
        .logic_supply_ok(supply[1]), .power_contact_ok(supply[0]),
        .status_lamp_ff(st_l), .upstream_link_activity_lamp(up_l),
        .downstream_link_activity_lamp(dn_l),
        .backplane_link_activity_lamp(bp_l),
        .logic_supply_lamp_ff(ls_l), .power_contact_lamp_ff(pc_l));
    csl_lamp_observer i_obs (.clk_sys(clk_sys), .clear(clr), .lamp(lamp),
        .lit_cnt_ff(lit_cnt), .rise_cnt_ff(rise_cnt));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic check(input string nm, input logic [7:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    task automatic apply(input logic [3:0] st, input logic [5:0] p);
        @(posedge clk_sys);
        slave_state <= st;
        ports       <= p;
    endtask
    // settle past sync, pattern and activity hold, then count a window
    task automatic measure(input logic [1:0] s, input int lit, rise);
        sel = s;
        repeat (12) @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        repeat (WIN) @(posedge clk_sys);
        #1;
        check($sformatf("lamp %0d lit cycles", s), 8'(lit), lit_cnt);
        check($sformatf("lamp %0d turn-ons", s), 8'(rise), rise_cnt);
    endtask
    task automatic st_case(input logic [3:0] st, input int lit, rise);
        apply(st, 6'h00);
        measure(2'h0, lit, rise);
    endtask
    // kind per lamp {bp, dn, up}: 0 dark, 1 steady, 2 flashing
    task automatic link_case(input logic [5:0] p, input logic [5:0] kind);
        logic [1:0] k;
        apply(CSL_ST_OP, p);
        for (int i = 1; i < 4; i++) begin
            k = kind[2 * (i - 1) +: 2];
            measure(2'(i), (k == 2'd1) ? WIN : (k == 2'd2) ? FL_LIT : 0,
                (k == 2'd2) ? FL_RISE : 0);
        end
    endtask
    task automatic supply_case(input logic [1:0] s);
        @(posedge clk_sys);
        supply <= s;
        repeat (6) @(posedge clk_sys);
        #1;
        check("logic supply lamp", {7'h0, s[1]}, {7'h0, ls_l});
        check("power contact lamp", {7'h0, s[0]}, {7'h0, pc_l});
    endtask
    task automatic complete_run();
        $display("checks made %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // main sequence: each named state and one unknown code, lamp kinds, then supplies
    initial begin
        failures        = 0;
        samples_checked = 0;
        reset_n         = 1'b0;
        clr             = 1'b0;
        sel             = 2'h0;
        supply          = 2'b00;
        ports           = 6'h00;
        slave_state     = CSL_ST_INIT;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        st_case(CSL_ST_OP, WIN, 0);
        st_case(CSL_ST_INIT, 0, 0);
        st_case(CSL_ST_PREOP, FL_LIT, FL_RISE);
        st_case(CSL_ST_SAFEOP, SG_LIT, SG_RISE);
        st_case(CSL_ST_BOOT, FL_LIT, FK_RISE);
        st_case(4'h0, 0, 0);
        link_case(6'b010101, 6'b000000);
        link_case(6'b101010, 6'b010101);
        link_case(6'b111111, 6'b101010);
        link_case(6'b110100, 6'b000010);
        link_case(6'b001110, 6'b011000);
        supply_case(2'b10);
        supply_case(2'b01);
        complete_run();
    end
endmodule
